// *** inc/rnc_cfg.svh ***
/*
  offsets, field positions, reset values and opcode constants of the
  rotate-without-carry unit; assumes inclusion by bare name only
*/
`ifndef RNC_CFG_SVH
`define RNC_CFG_SVH

`define RNC_CTRL_OFF       8'h00
`define RNC_BANK_OFF       8'h04
`define RNC_ACC_OFF        8'h08
`define RNC_STAT_OFF       8'h0C
`define RNC_BASE_OFF       8'h10
`define RNC_LAST_OFF       8'h14

`define RNC_CTRL_EN_BIT    0
`define RNC_CTRL_EXT_BIT   1
`define RNC_STAT_N_BIT     0
`define RNC_STAT_Z_BIT     1
`define RNC_STAT_BUSY_BIT  2
`define RNC_STAT_IGN_LSB   8

`define RNC_CTRL_RST       2'h1
`define RNC_BANK_RST       4'h0
`define RNC_ACC_RST        8'h00
`define RNC_BASE_RST       12'h000

`define RNC_PFX_ROT_LEFT   6'h11
`define RNC_PFX_ROT_RIGHT  6'h10
`define RNC_DEST_BIT       9
`define RNC_BANKSEL_BIT    8
`define RNC_INDEX_MAX      8'h5F
`define RNC_ACCESS_SPLIT   8'h60
`define RNC_ACCESS_HI_BANK 4'hF
`define RNC_ACCESS_LO_BANK 4'h0

`endif

// *** inc/rnc_pkg.sv ***
/*
  types and the opcode decoder of the rotate-without-carry unit;
  assumes rnc_cfg.svh on the include path
*/
`include "rnc_cfg.svh"

package rnc_pkg;

  typedef enum logic [1:0] {
    RNC_ST_DECODE,
    RNC_ST_READ,
    RNC_ST_PROCESS,
    RNC_ST_WRITE
  } rnc_state_type;

  typedef enum logic [1:0] {
    RNC_OP_NONE,
    RNC_OP_ROT_LEFT,
    RNC_OP_ROT_RIGHT
  } rnc_op_type;

  typedef enum logic [1:0] {
    RNC_MODE_ACCESS,
    RNC_MODE_BANK,
    RNC_MODE_INDEXED
  } rnc_mode_type;

  function automatic rnc_op_type rnc_decode(input logic [15:0] instr);
    rnc_op_type op;
    op = RNC_OP_NONE;
    if (instr[15:10] == `RNC_PFX_ROT_LEFT) begin
      op = RNC_OP_ROT_LEFT;
    end else if (instr[15:10] == `RNC_PFX_ROT_RIGHT) begin
      op = RNC_OP_ROT_RIGHT;
    end
    return op;
  endfunction

endpackage

// *** src/rnc_rotator.sv ***
/*
  byte rotator with negative and zero results;
  assumes a decoded operation from rnc_pkg, purely combinational
*/
`timescale 1ns/1ps

module rnc_rotator (
  input  wire rnc_pkg::rnc_op_type op_in,
  input  wire logic [7:0]          data_in,
  output logic [7:0]               result_out,
  output logic                     neg_out,
  output logic                     zero_out
);
  import rnc_pkg::*;

  // no carry port at all: the carry flag cannot be disturbed
  always_comb begin
    unique case (op_in)
      RNC_OP_ROT_LEFT:  result_out = {data_in[6:0], data_in[7]};
      RNC_OP_ROT_RIGHT: result_out = {data_in[0], data_in[7:1]};
      default:          result_out = data_in;
    endcase
    neg_out  = result_out[7];
    zero_out = (result_out == 8'h00);
  end
endmodule

// *** src/rnc_addr_gen.sv ***
/*
  operand address former: bank, access bank or indexed literal offset;
  assumes the bank and index base are held by the caller
*/
`timescale 1ns/1ps
`include "rnc_cfg.svh"

module rnc_addr_gen #(
  parameter int BANK_W = 4,
  parameter int ADDR_W = 12
) (
  input  wire logic [7:0]          file_in,
  input  wire logic                bank_sel_in,
  input  wire logic                ext_en_in,
  input  wire logic [BANK_W-1:0]   bank_select_reg_in,
  input  wire logic [ADDR_W-1:0]   index_base_in,
  output logic [ADDR_W-1:0]        addr_out,
  output rnc_pkg::rnc_mode_type    mode_out
);
  import rnc_pkg::*;

  logic [ADDR_W-1:0] indexed_sum;

  assign indexed_sum = index_base_in + {{(ADDR_W-8){1'b0}}, file_in};

  always_comb begin
    if (bank_sel_in) begin
      mode_out = RNC_MODE_BANK;
      addr_out = ADDR_W'({bank_select_reg_in, file_in});
    end else if (ext_en_in && (file_in <= `RNC_INDEX_MAX)) begin
      mode_out = RNC_MODE_INDEXED;
      addr_out = indexed_sum;
    end else begin
      // access bank: low part of bank 0 or top part of the last bank
      mode_out = RNC_MODE_ACCESS;
      if (file_in < `RNC_ACCESS_SPLIT) begin
        addr_out = ADDR_W'({`RNC_ACCESS_LO_BANK, file_in});
      end else begin
        addr_out = ADDR_W'({`RNC_ACCESS_HI_BANK, file_in});
      end
    end
  end
endmodule

// *** src/rnc_exec.sv ***
/*
  rotate-without-carry execution unit with an APB register slave;
  assumes data memory with one-cycle read latency and synchronous inputs
*/
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "rnc_cfg.svh"

module rnc_exec #(
  parameter int BANK_W = 4,
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              ce_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              instr_valid_in,
  input  wire logic [15:0]       instr_in,
  output logic                   instr_ready_out,
  output logic [ADDR_W-1:0]      mem_addr_out,
  output logic                   mem_rd_en_out,
  input  wire logic [7:0]        mem_rdata_in,
  output logic                   mem_wr_en_out,
  output logic [7:0]             mem_wdata_out,
  output logic [7:0]             acc_out,
  output logic                   flag_n_out,
  output logic                   flag_z_out,
  output logic                   done_out
);
  import rnc_pkg::*;

  rnc_state_type       state_reg, state_next;
  rnc_op_type          op_reg, op_next;
  rnc_mode_type        mode_reg, mode_next;
  logic [15:0]         instr_reg, instr_next;
  logic [ADDR_W-1:0]   addr_reg, addr_next;
  logic [7:0]          result_reg, result_next;
  logic [7:0]          acc_reg, acc_next;
  logic                n_reg, n_next;
  logic                z_reg, z_next;
  logic [7:0]          ign_reg, ign_next;

  logic [1:0]          ctrl_reg, ctrl_next;
  logic [BANK_W-1:0]   bank_select_reg, bank_select_next;
  logic [ADDR_W-1:0]   base_reg, base_next;
  logic [31:0]         prdata_reg, prdata_next;

  rnc_op_type          dec_op;
  rnc_mode_type        gen_mode;
  logic [ADDR_W-1:0]   gen_addr;
  logic [7:0]          rot_result;
  logic                rot_n;
  logic                rot_z;
  logic                accept;
  logic                apb_setup;
  logic                apb_wr;
  logic                addr_hit;

  assign dec_op = rnc_decode(instr_in);

  rnc_addr_gen #(
    .BANK_W (BANK_W),
    .ADDR_W (ADDR_W)
  ) u_addr (
    .file_in            (instr_in[7:0]),
    .bank_sel_in        (instr_in[`RNC_BANKSEL_BIT]),
    .ext_en_in          (ctrl_reg[`RNC_CTRL_EXT_BIT]),
    .bank_select_reg_in (bank_select_reg),
    .index_base_in      (base_reg),
    .addr_out           (gen_addr),
    .mode_out           (gen_mode)
  );

  // operand arrives one cycle after the read strobe, so feed it straight in
  rnc_rotator u_rot (
    .op_in      (op_reg),
    .data_in    (mem_rdata_in),
    .result_out (rot_result),
    .neg_out    (rot_n),
    .zero_out   (rot_z)
  );

  assign instr_ready_out = ce_in && ctrl_reg[`RNC_CTRL_EN_BIT] && (state_reg == RNC_ST_DECODE);
  assign accept          = instr_valid_in && instr_ready_out;
  assign mem_addr_out    = addr_reg;
  assign mem_wdata_out   = result_reg;
  assign mem_rd_en_out   = ce_in && (state_reg == RNC_ST_READ);
  assign mem_wr_en_out   = ce_in && (state_reg == RNC_ST_WRITE) && instr_reg[`RNC_DEST_BIT];
  assign done_out        = ce_in && (state_reg == RNC_ST_WRITE);
  assign acc_out         = acc_reg;
  assign flag_n_out      = n_reg;
  assign flag_z_out      = z_reg;

  // apb: zero wait states, but a frozen clock enable also stalls the bus
  assign pready_out  = ce_in;
  assign apb_setup   = psel_in && !penable_in;
  assign apb_wr      = psel_in && penable_in && pwrite_in && ce_in && addr_hit;
  assign prdata_out  = prdata_reg;
  assign pslverr_out = psel_in && penable_in && !addr_hit;

  always_comb begin
    unique case (paddr_in)
      `RNC_CTRL_OFF, `RNC_BANK_OFF, `RNC_ACC_OFF,
      `RNC_STAT_OFF, `RNC_BASE_OFF, `RNC_LAST_OFF: addr_hit = 1'b1;
      default:                                     addr_hit = 1'b0;
    endcase
  end

  // register file next values; read data is caught in the setup cycle
  always_comb begin
    ctrl_next        = ctrl_reg;
    bank_select_next = bank_select_reg;
    base_next        = base_reg;
    prdata_next      = prdata_reg;
    if (apb_wr && (paddr_in == `RNC_CTRL_OFF)) begin
      ctrl_next = pwdata_in[1:0];
    end
    if (apb_wr && (paddr_in == `RNC_BANK_OFF)) begin
      bank_select_next = pwdata_in[BANK_W-1:0];
    end
    if (apb_wr && (paddr_in == `RNC_BASE_OFF)) begin
      base_next = pwdata_in[ADDR_W-1:0];
    end
    if (apb_setup) begin
      prdata_next = 32'h0000_0000;
      unique case (paddr_in)
        `RNC_CTRL_OFF: prdata_next = {30'h0, ctrl_reg};
        `RNC_BANK_OFF: prdata_next = 32'(bank_select_reg);
        `RNC_ACC_OFF:  prdata_next = {24'h0, acc_reg};
        `RNC_STAT_OFF: prdata_next = {16'h0, ign_reg, 5'h0,
                                      (state_reg != RNC_ST_DECODE), z_reg, n_reg};
        `RNC_BASE_OFF: prdata_next = 32'(base_reg);
        `RNC_LAST_OFF: prdata_next = 32'(addr_reg);
        default:       prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_reg        <= `RNC_CTRL_RST;
      bank_select_reg <= BANK_W'(`RNC_BANK_RST);
      base_reg        <= ADDR_W'(`RNC_BASE_RST);
      prdata_reg      <= 32'h0000_0000;
    end else if (ce_in) begin
      ctrl_reg        <= ctrl_next;
      bank_select_reg <= bank_select_next;
      base_reg        <= base_next;
      prdata_reg      <= prdata_next;
    end
  end

  // four phases: decode, read operand, process, write destination
  always_comb begin
    state_next  = state_reg;
    op_next     = op_reg;
    mode_next   = mode_reg;
    instr_next  = instr_reg;
    addr_next   = addr_reg;
    result_next = result_reg;
    acc_next    = acc_reg;
    n_next      = n_reg;
    z_next      = z_reg;
    ign_next    = ign_reg;
    if (apb_wr && (paddr_in == `RNC_ACC_OFF)) begin
      acc_next = pwdata_in[7:0];
    end
    unique case (state_reg)
      RNC_ST_DECODE: begin
        if (accept && (dec_op != RNC_OP_NONE)) begin
          op_next    = dec_op;
          instr_next = instr_in;
          addr_next  = gen_addr;
          mode_next  = gen_mode;
          state_next = RNC_ST_READ;
        end else if (accept && (ign_reg != 8'hFF)) begin
          // foreign opcodes are consumed and counted, saturating
          ign_next = ign_reg + 8'h01;
        end
      end
      RNC_ST_READ: begin
        state_next = RNC_ST_PROCESS;
      end
      RNC_ST_PROCESS: begin
        result_next = rot_result;
        state_next  = RNC_ST_WRITE;
      end
      RNC_ST_WRITE: begin
        // the unit wins over a bus write landing in the same cycle
        if (!instr_reg[`RNC_DEST_BIT]) begin
          acc_next = result_reg;
        end
        n_next     = result_reg[7];
        z_next     = (result_reg == 8'h00);
        state_next = RNC_ST_DECODE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg  <= RNC_ST_DECODE;
      op_reg     <= RNC_OP_NONE;
      mode_reg   <= RNC_MODE_ACCESS;
      instr_reg  <= 16'h0000;
      addr_reg   <= '0;
      result_reg <= 8'h00;
      acc_reg    <= `RNC_ACC_RST;
      n_reg      <= 1'b0;
      z_reg      <= 1'b0;
      ign_reg    <= 8'h00;
    end else if (ce_in) begin
      state_reg  <= state_next;
      op_reg     <= op_next;
      mode_reg   <= mode_next;
      instr_reg  <= instr_next;
      addr_reg   <= addr_next;
      result_reg <= result_next;
      acc_reg    <= acc_next;
      n_reg      <= n_next;
      z_reg      <= z_next;
      ign_reg    <= ign_next;
    end
  end

  // checks: a frozen clock enable aborts any sequence in flight
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in || !ce_in);

  logic [7:0]        rdata_left;
  logic [7:0]        rdata_right;
  logic [ADDR_W-1:0] exp_index;

  assign rdata_left  = {mem_rdata_in[6:0], mem_rdata_in[7]};
  assign rdata_right = {mem_rdata_in[0], mem_rdata_in[7:1]};
  // whole address, so a lost carry into the bank bits is caught too
  assign exp_index   = base_reg + ADDR_W'(instr_reg[7:0]);

  rot_left_a: assert property (
    (state_reg == RNC_ST_PROCESS) && (op_reg == RNC_OP_ROT_LEFT)
      |=> (result_reg == $past(rdata_left))
  ) else $error("rotate left result wrong");

  rot_right_a: assert property (
    (state_reg == RNC_ST_PROCESS) && (op_reg == RNC_OP_ROT_RIGHT)
      |=> (result_reg == $past(rdata_right))
  ) else $error("rotate right result wrong");

  dest_acc_a: assert property (
    (state_reg == RNC_ST_WRITE) && !instr_reg[`RNC_DEST_BIT]
      |-> !mem_wr_en_out ##1 (acc_reg == $past(result_reg))
  ) else $error("accumulator destination not honoured");

  dest_file_a: assert property (
    (state_reg == RNC_ST_READ) && instr_reg[`RNC_DEST_BIT]
      |-> ##2 mem_wr_en_out && (mem_addr_out == $past(mem_addr_out, 2))
  ) else $error("write back to wrong register");

  access_bank_a: assert property (
    (state_reg == RNC_ST_READ) && (mode_reg == RNC_MODE_ACCESS)
      |-> !instr_reg[`RNC_BANKSEL_BIT]
          && (mem_addr_out[ADDR_W-1:8] == ((instr_reg[7:0] < `RNC_ACCESS_SPLIT) ? 4'h0 : 4'hF))
  ) else $error("access bank address wrong");

  bank_addr_a: assert property (
    (state_reg == RNC_ST_READ) && instr_reg[`RNC_BANKSEL_BIT]
      |-> (mode_reg == RNC_MODE_BANK) && (mem_addr_out[ADDR_W-1:8] == bank_select_reg)
  ) else $error("banked address wrong");

  indexed_mode_a: assert property (
    accept && (dec_op != RNC_OP_NONE) && !instr_in[`RNC_BANKSEL_BIT]
      && ctrl_reg[`RNC_CTRL_EXT_BIT] && (instr_in[7:0] <= `RNC_INDEX_MAX)
      |=> (mode_reg == RNC_MODE_INDEXED) && (mem_addr_out == exp_index)
  ) else $error("indexed offset not used");

  file_field_a: assert property (
    (state_reg == RNC_ST_READ) && (mode_reg != RNC_MODE_INDEXED)
      |-> (mem_addr_out[7:0] == instr_reg[7:0])
  ) else $error("file address field lost");

  one_cycle_a: assert property (
    accept && (dec_op != RNC_OP_NONE)
      |=> mem_rd_en_out ##2 done_out ##1 (state_reg == RNC_ST_DECODE)
          && (z_reg == (result_reg == 8'h00)) && (n_reg == result_reg[7])
  ) else $error("four phase sequence or flags wrong");

endmodule

// *** verification/rnc_mem_model.sv ***
/*
  data memory seen by the rotate unit: byte array, one-cycle read latency;
  assumes strobes are one-cycle pulses launched from the unit's clock
*/
`timescale 1ns/1ps

module rnc_mem_model #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              rd_en_in,
  input  wire logic              wr_en_in,
  input  wire logic [7:0]        wdata_in,
  output logic [7:0]             rdata_out
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] last_reg = 8'h00;
  logic       rd_reg   = 1'b0;

  always @(posedge clk_in) begin
    rd_reg <= rd_en_in;
    if (rd_en_in) begin
      last_reg <= mem[addr_in];
    end
    if (wr_en_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  // outside the valid cycle the bus shows the inverse, so a late or early sample is caught
  assign rdata_out = rd_reg ? last_reg : ~last_reg;
endmodule

// *** verification/rnc_exec_tb_top.sv ***
/*
  self-checking bench of the rotate unit: apb register access and rotate
  instructions; assumes rnc_exec and the memory model rnc_mem_model
*/
`timescale 1ns/1ps
`include "rnc_cfg.svh"

module rnc_exec_tb_top;
  import rnc_pkg::*;
  typedef struct packed {
    logic        left;
    logic        d;
    logic        a;
    logic        ext;
    logic [3:0]  bank;
    logic [11:0] base;
    logic [7:0]  f;
    logic [7:0]  v;
  } rnc_case_type;

  logic         clk = 1'b0;
  logic         nrst, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         instr_valid, instr_ready, mem_rd_en, mem_wr_en, flag_n, flag_z, done, err;
  logic [15:0]  instr;
  logic [11:0]  mem_addr, ea;
  logic [7:0]   mem_rdata, mem_wdata, acc, res, accp;
  int           bad_count = 0;
  int           total_checks = 0;
  rnc_case_type cases [6];
  rnc_case_type c;

  always #5 clk = ~clk;

  rnc_exec i_rnc_exec (.clk_in(clk), .nrst_in(nrst), .ce_in(ce), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .instr_valid_in(instr_valid), .instr_in(instr), .instr_ready_out(instr_ready),
    .mem_addr_out(mem_addr), .mem_rd_en_out(mem_rd_en), .mem_rdata_in(mem_rdata), .mem_wr_en_out(mem_wr_en),
    .mem_wdata_out(mem_wdata), .acc_out(acc), .flag_n_out(flag_n), .flag_z_out(flag_z), .done_out(done));

  rnc_mem_model i_rnc_mem_model (.clk_in(clk), .addr_in(mem_addr), .rd_en_in(mem_rd_en),
    .wr_en_in(mem_wr_en), .wdata_in(mem_wdata), .rdata_out(mem_rdata));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one apb transfer: setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // offer one instruction and follow its four phases
  task automatic run_instr(input logic [15:0] ins, input logic rot, input logic [11:0] addr,
                           input logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= ins;
    do begin
      @(negedge clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      end_sim();
    end
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    check("rd_en", 32'(mem_rd_en), 32'(rot));
    if (rot) begin
      check("mem_addr", 32'(mem_addr), 32'(addr));
    end
    @(negedge clk);
    check("done_early", 32'(done), 32'h0);
    @(negedge clk);
    check("done", 32'(done), 32'(rot));
    check("wr_en", 32'(mem_wr_en), 32'(rot & ins[`RNC_DEST_BIT]));
    if (rot) begin
      check("wdata", 32'(mem_wdata), 32'(r));
    end
    @(negedge clk);
  endtask

  function automatic logic [11:0] exp_addr(input rnc_case_type k);
    if (k.a) begin
      return {k.bank, k.f};
    end
    if (k.ext && k.f <= 8'h5F) begin
      return k.base + 12'(k.f);
    end
    return {(k.f < 8'h60) ? 4'h0 : 4'hF, k.f};
  endfunction

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    cases[0] = '{1'b1, 1'b1, 1'b1, 1'b0, 4'h3, 12'h000, 8'hFF, 8'hAB};
    cases[1] = '{1'b0, 1'b1, 1'b0, 1'b0, 4'h7, 12'h000, 8'h10, 8'hD7};
    cases[2] = '{1'b0, 1'b0, 1'b0, 1'b0, 4'h7, 12'h000, 8'h80, 8'hD7};
    cases[3] = '{1'b1, 1'b0, 1'b0, 1'b1, 4'h2, 12'h200, 8'h5F, 8'h80};
    cases[4] = '{1'b1, 1'b1, 1'b0, 1'b1, 4'h2, 12'h200, 8'h60, 8'h00};
    cases[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 4'h5, 12'h300, 8'h00, 8'h01};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, `RNC_CTRL_OFF, 32'h0, rd, err);
    check("ctrl_rst", rd, 32'h1);
    for (int k = 1; k < 6; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0, rd, err);
      check("reg_rst", rd, 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0, rd, err);
    check("unmapped_err", 32'(err), 32'h1);
    check("unmapped_data", rd, 32'h0);
    // a non-rotate prefix is consumed without touching memory
    run_instr(16'h0000, 1'b0, 12'h000, 8'h00);
    apb(1'b0, `RNC_STAT_OFF, 32'h0, rd, err);
    check("ignored_count", rd, 32'h0000_0100);
    foreach (cases[i]) begin
      c = cases[i];
      apb(1'b1, `RNC_CTRL_OFF, {30'h0, c.ext, 1'b1}, rd, err);
      apb(1'b1, `RNC_BANK_OFF, 32'(c.bank), rd, err);
      apb(1'b1, `RNC_BASE_OFF, 32'(c.base), rd, err);
      ea = exp_addr(c);
      i_rnc_mem_model.mem[ea] = c.v;
      res = c.left ? {c.v[6:0], c.v[7]} : {c.v[0], c.v[7:1]};
      accp = acc;
      run_instr({c.left ? `RNC_PFX_ROT_LEFT : `RNC_PFX_ROT_RIGHT, c.d, c.a, c.f}, 1'b1, ea, res);
      check("acc", 32'(acc), 32'(c.d ? accp : res));
      check("mem", 32'(i_rnc_mem_model.mem[ea]), 32'(c.d ? res : c.v));
      check("flag_n", 32'(flag_n), 32'(res[7]));
      check("flag_z", 32'(flag_z), 32'(res == 8'h00));
      apb(1'b0, `RNC_LAST_OFF, 32'h0, rd, err);
      check("last_addr", rd, 32'(ea));
    end
    apb(1'b0, `RNC_STAT_OFF, 32'h0, rd, err);
    check("status", rd, 32'h0000_0101);
    // bus write path, enable bit off, frozen clock enable, then a reset in mid-run
    apb(1'b1, `RNC_ACC_OFF, 32'h0000_005A, rd, err);
    check("acc_wr_err", 32'(err), 32'h0);
    apb(1'b0, `RNC_ACC_OFF, 32'h0, rd, err);
    check("acc_rd", rd, 32'h0000_005A);
    check("acc_out", 32'(acc), 32'h0000_005A);
    apb(1'b1, `RNC_CTRL_OFF, 32'h0, rd, err);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= {`RNC_PFX_ROT_LEFT, 10'h3FF};
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("ready_off", 32'(instr_ready), 32'h0);
    check("rd_en_off", 32'(mem_rd_en), 32'h0);
    @(posedge clk);
    instr_valid <= 1'b0;
    ce <= 1'b0;
    @(negedge clk);
    check("pready_frozen", 32'(pready), 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, `RNC_ACC_OFF, 32'h0, rd, err);
    check("acc_rst2", rd, 32'h0);
    apb(1'b0, `RNC_CTRL_OFF, 32'h0, rd, err);
    check("ctrl_rst2", rd, 32'h1);
    end_sim();
  end
endmodule
